// *** testbench/frame_memory_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// frame memory stand-in, logs every word
// ----------------------------------------
module frame_memory_model #(
  parameter int DATA_W = 18
) (
  input  wire logic              sys_clk,
  input  wire logic              stall,
  input  wire logic              mem_valid,
  output logic                   mem_ready,
  input  wire logic [15:0]       mem_column,
  input  wire logic [15:0]       mem_row,
  input  wire logic [DATA_W-1:0] mem_data,
  output logic [DATA_W-1:0]      frame_pixel
);
  logic [15:0]       col_log[32];
  logic [15:0]       row_log[32];
  logic [DATA_W-1:0] data_log[32];
  int                n_writes = 0;
  // last word written; a fixed pattern at first so inversion shows
  logic [DATA_W-1:0] last_word = DATA_W'(18'h2A5C3);
  // slow answer only when the bench stalls, to fill the buffer
  assign mem_ready   = ~stall;
  assign frame_pixel = last_word;
  always @(posedge sys_clk) begin
    if (mem_valid && mem_ready) begin
      col_log[n_writes % 32]  <= mem_column;
      row_log[n_writes % 32]  <= mem_row;
      data_log[n_writes % 32] <= mem_data;
      last_word               <= mem_data;
      n_writes                <= n_writes + 1;
    end
  end
endmodule // frame_memory_model
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int DATA_W = 18;
  typedef struct {
    logic [7:0] cmd;
    logic [8:0] par;
    logic       inv;
    logic       en;
    logic [3:0] g;
  } row_t;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              sw_reset = 1'b0;
  logic              stall = 1'b0;
  logic              strobe = 1'b0;
  logic              sel = 1'b0;
  logic              exch = 1'b0;
  logic [DATA_W-1:0] hd = '0;
  logic              mem_valid, mem_ready, host_ready, panel_enable, inv_on;
  logic [15:0]       mem_column, mem_row;
  logic [DATA_W-1:0] mem_data, frame_pixel, panel_pixel;
  logic [3:0]        gamma;
  int                n_fail = 0, checks = 0, cyc = 0, base, k;
  // ----------------------------------------
  // ordinary cases: command, parameter, resulting state
  // ----------------------------------------
  row_t rows[16] = '{
    '{8'h29, 9'h000, 1'b0, 1'b1, 4'h1}, '{8'h29, 9'h000, 1'b0, 1'b1, 4'h1},
    '{8'h21, 9'h000, 1'b1, 1'b1, 4'h1}, '{8'h21, 9'h000, 1'b1, 1'b1, 4'h1},
    '{8'h00, 9'h000, 1'b1, 1'b1, 4'h1}, '{8'h20, 9'h000, 1'b0, 1'b1, 4'h1},
    '{8'h20, 9'h000, 1'b0, 1'b1, 4'h1}, '{8'h21, 9'h000, 1'b1, 1'b1, 4'h1},
    '{8'h28, 9'h000, 1'b1, 1'b0, 4'h1}, '{8'h28, 9'h000, 1'b1, 1'b0, 4'h1},
    '{8'h26, 9'h102, 1'b1, 1'b0, 4'h2}, '{8'h26, 9'h104, 1'b1, 1'b0, 4'h4},
    '{8'h26, 9'h108, 1'b1, 1'b0, 4'h8}, '{8'h26, 9'h103, 1'b1, 1'b0, 4'h8},
    '{8'h26, 9'h100, 1'b1, 1'b0, 4'h8}, '{8'h26, 9'h101, 1'b1, 1'b0, 4'h1}};
  display_window_command_decoder #(.DATA_W(DATA_W))
    display_window_command_decoder_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .sw_reset(sw_reset),
    .host_write_strobe(strobe), .command_parameter_select(sel),
    .host_data(hd), .row_column_exchange(exch), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_column(mem_column), .mem_row(mem_row),
    .mem_data(mem_data), .host_ready(host_ready),
    .frame_pixel(frame_pixel), .panel_pixel(panel_pixel),
    .panel_enable(panel_enable), .inversion_on(inv_on),
    .gamma_curve_bits(gamma));
  frame_memory_model #(.DATA_W(DATA_W)) frame_memory_model_inst (
    .sys_clk(sys_clk), .stall(stall), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_column(mem_column), .mem_row(mem_row),
    .mem_data(mem_data), .frame_pixel(frame_pixel));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one idle cycle after each strobe keeps assignments one per time step
  task automatic send(input logic cp, input logic [DATA_W-1:0] d);
    strobe <= 1'b1;
    sel <= cp;
    hd <= d;
    @(posedge sys_clk);
    strobe <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic win(input logic [7:0] c, input logic [15:0] s, e);
    send(1'b0, DATA_W'(c));
    send(1'b1, DATA_W'(s[15:8]));
    send(1'b1, DATA_W'(s[7:0]));
    send(1'b1, DATA_W'(e[15:8]));
    send(1'b1, DATA_W'(e[7:0]));
  endtask
  task automatic burst(input int n);
    base = frame_memory_model_inst.n_writes;
    send(1'b0, DATA_W'(8'h2C));
    for (int i = 0; i < n; i++)
      send(1'b1, DATA_W'(18'h30000 + i));
    repeat (12) @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({inv_on, panel_enable, gamma, mem_valid}, 7'h02, "reset");
    foreach (rows[i]) begin
      send(1'b0, DATA_W'(rows[i].cmd));
      if (rows[i].par[8])
        send(1'b1, DATA_W'(rows[i].par[7:0]));
      #1;
      chk(inv_on, rows[i].inv, "inv");
      chk(panel_enable, rows[i].en,
          "en");
      chk(gamma, rows[i].g, "gamma");
      // cast keeps the inversion at pixel width, not the compare width
      chk(panel_pixel, !rows[i].en ? '0
          : rows[i].inv ? DATA_W'(~frame_pixel)
          : frame_pixel, "panel");
    end
    win(8'h2A, 16'h0005, 16'h0006);
    win(8'h2B, 16'h0003, 16'h0004);
    burst(5);
    for (int i = 0; i < 5; i++) begin
      k = (base + i) % 32;
      chk(frame_memory_model_inst.col_log[k], 5 + i % 2,
          "col");
      chk(frame_memory_model_inst.row_log[k], 3 + i / 2 % 2,
          "row");
      chk(frame_memory_model_inst.data_log[k], 18'h30000 + i,
          "data");
    end
    send(1'b0, DATA_W'(8'h20));
    send(1'b1, DATA_W'(18'h1FFFF));
    repeat (4) @(posedge sys_clk);
    #1;
    chk(frame_memory_model_inst.n_writes, base + 5, "ended");
    for (int m = 0; m < 2; m++) begin
      exch <= m[0];
      win(8'h2A, m ? 16'h009E : 16'h007E,
          m ? 16'h00A0 : 16'h0080);
      burst(3);
      chk(frame_memory_model_inst.n_writes - base, 2, "limit");
      chk(frame_memory_model_inst.col_log[(base + 1) % 32],
          m ? 16'h009F : 16'h007F, "last");
    end
    win(8'h2A, 16'h0005, 16'h0006);
    stall <= 1'b1;
    base = frame_memory_model_inst.n_writes;
    send(1'b0, DATA_W'(8'h2C));
    k = 0;
    #1;
    while (host_ready === 1'b1 && k < 8) begin
      send(1'b1, DATA_W'(18'h10000 + k));
      k++;
      #1;
    end
    chk(host_ready, 1'b0, "full");
    chk(frame_memory_model_inst.n_writes, base, "stalled");
    stall <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(frame_memory_model_inst.n_writes - base, k, "drained");
    chk(frame_memory_model_inst.data_log[(base + k - 1) % 32],
        18'h10000 + k - 1, "order");
    chk(mem_valid, 1'b0, "empty");
    // move every defaulted state away from reset so the reset shows
    send(1'b0, DATA_W'(8'h21));
    send(1'b0, DATA_W'(8'h26));
    send(1'b1, DATA_W'(8'h04));
    send(1'b0, DATA_W'(8'h29));
    sw_reset <= 1'b1;
    @(posedge sys_clk);
    sw_reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({inv_on, panel_enable, gamma}, 6'h01,
        "sw reset");
    burst(1);
    chk(frame_memory_model_inst.col_log[base % 32], 16'h0000, "col0");
    chk(frame_memory_model_inst.row_log[base % 32], 16'h0000, "row0");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire

// *** verilog/disp_cmd_pkg.sv ***
// Overview of operation
// - 20h leaves inversion, memory untouched
// - 21h inverts every bit toward panel
// - 26h one-hot parameter picks gamma curve
// - selected curve only reported on gamma_curve_bits, not applied to panel_pixel, four curves
// - 28h blanks panel output, memory untouched
// - 29h resumes frame memory to panel
// - display-on ignored when already on
// - 2Ah four bytes set column window
// - column window used by next memory write
// - columns beyond 7Fh or 9Fh ignored
// - column reset defaults depend on reset kind
// - 2Bh four bytes set row window
// - 2Ch resets pointers, streams words, advances
package disp_cmd_pkg;
  localparam logic [7:0] CMD_INV_OFF   = 8'h20;
  localparam logic [7:0] CMD_INV_ON    = 8'h21;
  localparam logic [7:0] CMD_GAMMA     = 8'h26;
  localparam logic [7:0] CMD_DISP_OFF  = 8'h28;
  localparam logic [7:0] CMD_DISP_ON   = 8'h29;
  localparam logic [7:0] CMD_COL_WIN   = 8'h2A;
  localparam logic [7:0] CMD_ROW_WIN   = 8'h2B;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
  localparam logic [3:0] GAMMA_RESET   = 4'h1;
  localparam logic [15:0] COL_START_RESET  = 16'h0000;
  localparam logic [15:0] COL_END_RESET    = 16'h00EF;
  localparam logic [15:0] COL_END_RESET_MV = 16'h013F;
  localparam logic [15:0] ROW_START_RESET  = 16'h0000;
  localparam logic [15:0] ROW_END_RESET    = 16'h013F;
  localparam logic [15:0] COL_LIMIT        = 16'h007F;
  localparam logic [15:0] COL_LIMIT_MV     = 16'h009F;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PARAM = 2'b01,
    ST_WRITE = 2'b10
  } state_t;
endpackage

// *** verilog/display_window_command_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module display_window_command_decoder #(
  parameter int DATA_W = 18
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              sw_reset,
  // host write side
  input  wire logic              host_write_strobe,
  input  wire logic              command_parameter_select,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic              row_column_exchange,
  // frame memory write side
  output logic                   mem_valid,
  input  wire logic              mem_ready,
  output logic [15:0]            mem_column,
  output logic [15:0]            mem_row,
  output logic [DATA_W-1:0]      mem_data,
  output logic                   host_ready,
  // panel path
  input  wire logic [DATA_W-1:0] frame_pixel,
  output logic [DATA_W-1:0]      panel_pixel,
  output logic                   panel_enable,
  output logic                   inversion_on,
  output logic [3:0]             gamma_curve_bits
);

  // ----------------------------------------------------------------
  // command and window state
  // ----------------------------------------------------------------
  disp_cmd_pkg::state_t state;
  disp_cmd_pkg::state_t next_state;
  logic [7:0]  cmd;
  logic [7:0]  next_cmd;
  logic [1:0]  pcount;
  logic [1:0]  next_pcount;
  logic [7:0]  hi_byte;
  logic [7:0]  next_hi_byte;
  logic [15:0] col_start, col_end, row_start, row_end;
  logic [15:0] next_col_start, next_col_end;
  logic [15:0] next_row_start, next_row_end;
  logic [15:0] col_ptr, row_ptr, next_col_ptr, next_row_ptr;
  logic        inv, next_inv, disp, next_disp;
  logic [3:0]  gamma, next_gamma;
  logic        wr_push;
  logic        wr_in_range;
  logic [15:0] col_limit;
  logic        buf_in_ready;
  logic        cmd_strobe;
  logic        par_strobe;
  logic [15:0] word16;

  assign cmd_strobe = host_write_strobe && !command_parameter_select;
  assign par_strobe = host_write_strobe && command_parameter_select;
  assign word16     = {hi_byte, host_data[7:0]};
  assign col_limit  = row_column_exchange ? disp_cmd_pkg::COL_LIMIT_MV
                                          : disp_cmd_pkg::COL_LIMIT;
  // columns past the addressable range are dropped, pointers still move
  assign wr_in_range = (col_ptr <= col_limit);

  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_pcount    = pcount;
    next_hi_byte   = hi_byte;
    next_col_start = col_start;
    next_col_end   = col_end;
    next_row_start = row_start;
    next_row_end   = row_end;
    next_col_ptr   = col_ptr;
    next_row_ptr   = row_ptr;
    next_inv       = inv;
    next_disp      = disp;
    next_gamma     = gamma;
    wr_push        = 1'b0;
    if (cmd_strobe) begin
      // any new command ends a running memory write
      next_cmd    = host_data[7:0];
      next_pcount = 2'd0;
      next_state  = disp_cmd_pkg::ST_IDLE;
      case (host_data[7:0])
        // setting to the present value is harmless, so no-op is free
        disp_cmd_pkg::CMD_INV_OFF:  next_inv  = 1'b0;
        disp_cmd_pkg::CMD_INV_ON:   next_inv  = 1'b1;
        disp_cmd_pkg::CMD_DISP_OFF: next_disp = 1'b0;
        disp_cmd_pkg::CMD_DISP_ON:  next_disp = 1'b1;
        disp_cmd_pkg::CMD_GAMMA,
        disp_cmd_pkg::CMD_COL_WIN,
        disp_cmd_pkg::CMD_ROW_WIN:  next_state = disp_cmd_pkg::ST_PARAM;
        disp_cmd_pkg::CMD_MEM_WRITE: begin
          next_state   = disp_cmd_pkg::ST_WRITE;
          next_col_ptr = col_start;
          next_row_ptr = row_start;
        end
        default: next_state = disp_cmd_pkg::ST_IDLE;
      endcase
    end else if (par_strobe) begin
      case (state)
        disp_cmd_pkg::ST_PARAM: begin
          next_pcount  = pcount + 2'd1;
          next_hi_byte = host_data[7:0];
          if (cmd == disp_cmd_pkg::CMD_GAMMA) begin
            next_state = disp_cmd_pkg::ST_IDLE;
            case (host_data[7:0])
              8'h01, 8'h02, 8'h04, 8'h08:
                next_gamma = host_data[3:0];
              default: next_gamma = gamma;
            endcase
          end else begin
            if (pcount == 2'd1) begin
              if (cmd == disp_cmd_pkg::CMD_COL_WIN)
                next_col_start = word16;
              else
                next_row_start = word16;
            end
            if (pcount == 2'd3) begin
              next_state = disp_cmd_pkg::ST_IDLE;
              if (cmd == disp_cmd_pkg::CMD_COL_WIN)
                next_col_end = word16;
              else
                next_row_end = word16;
            end
          end
        end
        disp_cmd_pkg::ST_WRITE: begin
          if (buf_in_ready) begin
            wr_push = wr_in_range;
            if (col_ptr >= col_end) begin
              next_col_ptr = col_start;
              next_row_ptr = (row_ptr >= row_end) ? row_start
                                                  : row_ptr + 16'h0001;
            end else begin
              next_col_ptr = col_ptr + 16'h0001;
            end
          end
        end
        default: next_state = disp_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || sw_reset) begin
      state     <= disp_cmd_pkg::ST_IDLE;
      cmd       <= 8'h00;
      pcount    <= 2'd0;
      hi_byte   <= 8'h00;
      col_start <= disp_cmd_pkg::COL_START_RESET;
      row_start <= disp_cmd_pkg::ROW_START_RESET;
      row_end   <= disp_cmd_pkg::ROW_END_RESET;
      col_ptr   <= 16'h0000;
      row_ptr   <= 16'h0000;
      inv       <= 1'b0;
      disp      <= 1'b0;
      gamma     <= disp_cmd_pkg::GAMMA_RESET;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      pcount    <= next_pcount;
      hi_byte   <= next_hi_byte;
      col_start <= next_col_start;
      row_start <= next_row_start;
      row_end   <= next_row_end;
      col_ptr   <= next_col_ptr;
      row_ptr   <= next_row_ptr;
      inv       <= next_inv;
      disp      <= next_disp;
      gamma     <= next_gamma;
    end
  end

  // end column default differs: software reset honours exchange mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      col_end <= disp_cmd_pkg::COL_END_RESET;
    else if (sw_reset)
      col_end <= row_column_exchange ? disp_cmd_pkg::COL_END_RESET_MV
                                     : disp_cmd_pkg::COL_END_RESET;
    else
      col_end <= next_col_end;
  end

  // ----------------------------------------------------------------
  // two-entry write buffer
  // ----------------------------------------------------------------
  localparam int ENTRY_W = DATA_W + 32;
  logic [ENTRY_W-1:0] slot0, slot1, next_slot0, next_slot1;
  logic [1:0]         fill, next_fill;
  logic               pop;

  assign buf_in_ready = (fill != 2'd2);
  assign pop          = mem_valid && mem_ready;

  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_fill  = fill;
    if (pop) begin
      next_slot0 = slot1;
      next_fill  = next_fill - 2'd1;
    end
    if (wr_push) begin
      if (next_fill == 2'd0)
        next_slot0 = {col_ptr, row_ptr, host_data};
      else
        next_slot1 = {col_ptr, row_ptr, host_data};
      next_fill = next_fill + 2'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      slot0 <= '0;
      slot1 <= '0;
      fill  <= 2'd0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      fill  <= next_fill;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_panel_pixel;
  always_comb begin
    next_panel_pixel = '0; // blank page when output is off
    if (next_disp)
      next_panel_pixel = next_inv ? ~frame_pixel
                                  : frame_pixel;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mem_valid        <= 1'b0;
      mem_column       <= 16'h0000;
      mem_row          <= 16'h0000;
      mem_data         <= '0;
      host_ready       <= 1'b0;
      panel_pixel      <= '0;
      panel_enable     <= 1'b0;
      inversion_on     <= 1'b0;
      gamma_curve_bits <= disp_cmd_pkg::GAMMA_RESET;
    end else begin
      mem_valid        <= (next_fill != 2'd0);
      mem_column       <= next_slot0[ENTRY_W-1 -: 16];
      mem_row          <= next_slot0[DATA_W+15 -: 16];
      mem_data         <= next_slot0[DATA_W-1:0];
      host_ready       <= (next_fill != 2'd2);
      panel_pixel      <= next_panel_pixel;
      panel_enable     <= next_disp;
      inversion_on     <= next_inv;
      gamma_curve_bits <= next_gamma;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_inv_on_cmd: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_strobe && host_data[7:0] == disp_cmd_pkg::CMD_INV_ON && !sw_reset
    |=> ##1 inversion_on) else $error("inversion not entered");
  a_inv_off_cmd: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_strobe && host_data[7:0] == disp_cmd_pkg::CMD_INV_OFF && !sw_reset
    |=> ##1 !inversion_on) else $error("inversion not left");
  a_disp_off_blank: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !panel_enable |-> panel_pixel == '0)
    else $error("panel not blank");
  a_disp_off_cmd: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_strobe && host_data[7:0] == disp_cmd_pkg::CMD_DISP_OFF && !sw_reset
    |=> ##1 !panel_enable) else $error("display not off");
  a_disp_on_cmd: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_strobe && host_data[7:0] == disp_cmd_pkg::CMD_DISP_ON && !sw_reset
    |=> ##1 panel_enable) else $error("display not on");
  a_gamma_onehot: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $onehot(gamma_curve_bits)) else $error("gamma not one-hot");
  a_gamma_keep: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (par_strobe && state == disp_cmd_pkg::ST_PARAM && !sw_reset
     && cmd == disp_cmd_pkg::CMD_GAMMA
     && (host_data[7:4] != 4'h0 || !$onehot(host_data[3:0])))
    |=> gamma == $past(gamma)) else $error("invalid gamma applied");
  a_write_start: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_strobe && host_data[7:0] == disp_cmd_pkg::CMD_MEM_WRITE && !sw_reset
    |=> col_ptr == $past(col_start) && row_ptr == $past(row_start))
    else $error("pointers not at window start");
  a_ptr_window: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    state == disp_cmd_pkg::ST_WRITE |-> col_ptr >= col_start
    && col_ptr <= col_end && row_ptr >= row_start && row_ptr <= row_end)
    else $error("pointer outside window");
  // checked at the memory side, where a dropped column must never appear
  a_col_range: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mem_valid |-> mem_column <= col_limit)
    else $error("out of range column written");
  a_sw_reset_off: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sw_reset |=> !inv && !disp && gamma == disp_cmd_pkg::GAMMA_RESET)
    else $error("soft reset defaults wrong");
  c_write_burst: cover property (@(posedge sys_clk) wr_push ##1 wr_push);
  c_buffer_full: cover property (@(posedge sys_clk) fill == 2'd2);
  c_gamma_four: cover property (@(posedge sys_clk) gamma == 4'h8);

endmodule // display_window_command_decoder
`default_nettype wire
